// >>> verilog/lpm_ctrl.sv
// Low-power mode controller: idle and power-down clock gating
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module lpm_ctrl (
	// Clock and reset
	input  wire logic     CLK_SYS,
	input  wire logic     RST_N,
	// Instruction sequencer
	input  wire logic     IDLE_EXEC,
	output var  logic     CORE_STALL,
	output var  logic     RESUME,
	output var  logic     PIPE_FLUSH,
	// Power control bits of the pll_control_register
	input  wire logic     FULL_POWER_DOWN_BIT,
	input  wire logic     STOP_CORE_AND_PERIPH_BIT,
	input  wire logic     STOP_CORE_CLOCK_BIT,
	// Wake sources
	input  wire logic     IRQ_REQ,
	input  wire logic     WAKE_EVT,
	// Clock gating
	output var  logic     CORE_CLK_EN,
	output var  logic     PERIPH_CLK_EN,
	output var  logic     PLL_EN,
	// Status
	output var  logic [2:0] MODE
);
	import lpm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Reset release synchroniser

	logic [1:0] rst_sync_q;
	logic       rst_n_s;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n_s = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		lpm_state_e state;
		logic       from_lossy;
		logic       wake_m;
		logic       wake_s;
		logic       resume;
		logic       flush;
		logic       core_en;
		logic       per_en;
		logic       pll_en;
		logic       stall;
		logic [2:0] mode;
	} lpm_ctrl_s;

	localparam lpm_ctrl_s CTRL_RST = '{
		state:      LPM_RUN,
		from_lossy: 1'b0,
		wake_m:     1'b0,
		wake_s:     1'b0,
		resume:     1'b0,
		flush:      1'b0,
		core_en:    CLK_EN_RST,
		per_en:     CLK_EN_RST,
		pll_en:     CLK_EN_RST,
		stall:      STALL_RST,
		mode:       MODE_RUN
	};

	lpm_ctrl_s st_q;
	lpm_ctrl_s st_d;

	lpm_tmr_if tif ();

	lpm_wake_tmr u_tmr (
		.clk   (CLK_SYS),
		.rst_n (rst_n_s),
		.tif   (tif)
	);

	// Low-power state selected by the control bits, by priority
	function automatic lpm_state_e pick_state(input logic full,
	                                          input logic all,
	                                          input logic core);
		if (full) begin
			pick_state = LPM_PDALL;
		end else if (all) begin
			pick_state = LPM_PDCP;
		end else if (core) begin
			pick_state = LPM_PDCORE;
		end else begin
			pick_state = LPM_IDLE;
		end
	endfunction

	// Mode code of a state
	function automatic logic [2:0] mode_of(input lpm_state_e s);
		case (s)
			LPM_IDLE:   mode_of = MODE_IDLE;
			LPM_PDCORE: mode_of = MODE_PDCORE;
			LPM_PDCP:   mode_of = MODE_PDCP;
			LPM_PDALL:  mode_of = MODE_PDALL;
			LPM_WAKE:   mode_of = MODE_WAKE;
			default:    mode_of = MODE_RUN;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d          = st_q;
		st_d.wake_m   = WAKE_EVT;
		st_d.wake_s   = st_q.wake_m;
		st_d.resume   = 1'b0;
		st_d.flush    = 1'b0;
		tif.load      = 1'b0;
		tif.load_val  = TMR_RST;
		case (st_q.state)
			LPM_RUN: begin
				// Only the idle instruction leaves normal running
				if (IDLE_EXEC) begin
					st_d.state = pick_state(FULL_POWER_DOWN_BIT,
					                        STOP_CORE_AND_PERIPH_BIT,
					                        STOP_CORE_CLOCK_BIT);
				end
			end
			LPM_IDLE: begin
				if (IRQ_REQ) begin
					st_d.state      = LPM_WAKE;
					st_d.from_lossy = 1'b0;
					tif.load        = 1'b1;
					tif.load_val    = lpm_cnt_t'(LAT_IDLE_CYC - 1);
				end
			end
			LPM_PDCORE: begin
				if (IRQ_REQ) begin
					st_d.state      = LPM_WAKE;
					st_d.from_lossy = 1'b0;
					tif.load        = 1'b1;
					tif.load_val    = lpm_cnt_t'(LAT_PDCORE_CYC - 1);
				end
			end
			LPM_PDCP: begin
				// Peripherals are stopped, so the pin event or an interrupt
				if (st_q.wake_s || IRQ_REQ) begin
					st_d.state      = LPM_WAKE;
					st_d.from_lossy = 1'b1;
					tif.load        = 1'b1;
					tif.load_val    = lpm_cnt_t'(LAT_PDCP_CYC - 1);
				end
			end
			LPM_PDALL: begin
				if (IRQ_REQ) begin
					st_d.state      = LPM_WAKE;
					st_d.from_lossy = 1'b1;
					tif.load        = 1'b1;
					tif.load_val    = lpm_cnt_t'(LAT_PDALL_CYC - 1);
				end
			end
			LPM_WAKE: begin
				if (tif.done) begin
					st_d.state  = LPM_RUN;
					st_d.resume = 1'b1;
					// Lossy modes dropped the pipeline; refetch after idle
					st_d.flush  = st_q.from_lossy;
				end
			end
			default: begin
				st_d.state = LPM_RUN;
			end
		endcase

		// Clock gating follows the next state so enables are registered
		st_d.core_en = (st_d.state == LPM_RUN) || (st_d.state == LPM_IDLE)
		               || (st_d.state == LPM_WAKE);
		st_d.per_en  = (st_d.state != LPM_PDCP)
		               && (st_d.state != LPM_PDALL);
		st_d.pll_en  = (st_d.state != LPM_PDALL);
		st_d.stall   = (st_d.state != LPM_RUN);
		st_d.mode    = mode_of(st_d.state);
	end

	always_ff @(posedge CLK_SYS or negedge rst_n_s) begin
		if (!rst_n_s) begin
			st_q <= CTRL_RST;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign CORE_STALL    = st_q.stall;
	assign RESUME        = st_q.resume;
	assign PIPE_FLUSH    = st_q.flush;
	assign CORE_CLK_EN   = st_q.core_en;
	assign PERIPH_CLK_EN = st_q.per_en;
	assign PLL_EN        = st_q.pll_en;
	assign MODE          = st_q.mode;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge CLK_SYS);
	endclocking

	default disable iff (!rst_n_s);

	sequence s_run_idle;
		st_q.state == LPM_RUN && IDLE_EXEC;
	endsequence

	sequence s_bits_none;
		!FULL_POWER_DOWN_BIT && !STOP_CORE_AND_PERIPH_BIT
		&& !STOP_CORE_CLOCK_BIT;
	endsequence

	sequence s_resumed_keep;
		RESUME && !PIPE_FLUSH && MODE == MODE_RUN;
	endsequence

	sequence s_resumed_flush;
		RESUME && PIPE_FLUSH && MODE == MODE_RUN;
	endsequence

	AST_ENTRY_ONLY_ON_IDLE: assert property (
		st_q.state == LPM_RUN && !IDLE_EXEC |=> st_q.state == LPM_RUN
	) else $error("left run state without idle instruction");

	AST_IDLE_CLOCKS_RUN: assert property (
		MODE == MODE_IDLE |-> CORE_CLK_EN && PERIPH_CLK_EN && PLL_EN
		&& CORE_STALL
	) else $error("plain idle gated a clock or did not stall");

	AST_IDLE_ENTRY: assert property (
		s_run_idle and s_bits_none |=> MODE == MODE_IDLE && CORE_STALL
	) else $error("idle instruction with no bits did not give idle");

	AST_IDLE_WAKE_LAT: assert property (
		MODE == MODE_IDLE && IRQ_REQ |-> !RESUME ##1 !RESUME
		##1 s_resumed_keep
	) else $error("idle wake latency is not two cycles");

	AST_PDCORE_GATING: assert property (
		MODE == MODE_PDCORE |-> !CORE_CLK_EN && PERIPH_CLK_EN && PLL_EN
	) else $error("core power-down gating wrong");

	AST_PDCORE_ENTRY: assert property (
		s_run_idle ##0 (!FULL_POWER_DOWN_BIT && !STOP_CORE_AND_PERIPH_BIT
		&& STOP_CORE_CLOCK_BIT) |=> MODE == MODE_PDCORE
	) else $error("core power-down not selected");

	AST_PDCORE_WAKE_LAT: assert property (
		MODE == MODE_PDCORE && IRQ_REQ |-> ##2 s_resumed_keep
	) else $error("core power-down wake latency is not two cycles");

	AST_PDCP_GATING: assert property (
		MODE == MODE_PDCP |-> !CORE_CLK_EN && !PERIPH_CLK_EN && PLL_EN
	) else $error("core and peripheral power-down gating wrong");

	AST_PDCP_ENTRY: assert property (
		s_run_idle ##0 (!FULL_POWER_DOWN_BIT && STOP_CORE_AND_PERIPH_BIT)
		|=> MODE == MODE_PDCP
	) else $error("core and peripheral power-down not selected");

	AST_PDCP_WAKE_LAT: assert property (
		MODE == MODE_PDCP && (st_q.wake_s || IRQ_REQ) |->
		(!RESUME)[*5] ##1 s_resumed_flush
	) else $error("core and peripheral wake latency wrong");

	AST_PDALL_GATING: assert property (
		MODE == MODE_PDALL |-> !CORE_CLK_EN && !PERIPH_CLK_EN && !PLL_EN
	) else $error("full power-down left a clock running");

	AST_PDALL_ENTRY: assert property (
		s_run_idle ##0 FULL_POWER_DOWN_BIT |=> MODE == MODE_PDALL
	) else $error("full power-down not selected or lost priority");

	AST_PDALL_WAKE_LAT: assert property (
		MODE == MODE_PDALL && IRQ_REQ |-> ##1 (PLL_EN && !RESUME)
		##[499:499] s_resumed_flush
	) else $error("full power-down wake latency is not 500 cycles");

	AST_PRIORITY_STOP_CORE_AND_PERIPH_BIT: assert property (
		s_run_idle ##0 (!FULL_POWER_DOWN_BIT && STOP_CORE_AND_PERIPH_BIT
		&& STOP_CORE_CLOCK_BIT) |=> MODE != MODE_PDCORE
	) else $error("stop-core won over stop-all");

endmodule

`default_nettype wire

// >>> verilog/lpm_pkg.sv
// Constants and types shared by the low-power mode controller
package lpm_pkg;

	// Wake-up latencies, in core clock cycles
	localparam int unsigned LAT_IDLE_CYC   = 2;
	localparam int unsigned LAT_PDCORE_CYC = 2;
	localparam int unsigned LAT_PDCP_CYC   = 5;
	localparam int unsigned LAT_PDALL_CYC  = 500;

	// Wake timer width, wide enough for the longest latency
	localparam int unsigned TMR_W = 9;

	typedef logic [TMR_W-1:0] lpm_cnt_t;

	localparam lpm_cnt_t TMR_RST = 9'h000;
	localparam lpm_cnt_t TMR_ONE = 9'h001;

	// Reset values of the controller outputs
	localparam logic CLK_EN_RST = 1'b1;
	localparam logic STALL_RST  = 1'b0;

	// Controller states, one-hot
	typedef enum logic [5:0] {
		LPM_RUN    = 6'h01,
		LPM_IDLE   = 6'h02,
		LPM_PDCORE = 6'h04,
		LPM_PDCP   = 6'h08,
		LPM_PDALL  = 6'h10,
		LPM_WAKE   = 6'h20
	} lpm_state_e;

	// Mode code shown on the status output
	localparam logic [2:0] MODE_RUN    = 3'h0;
	localparam logic [2:0] MODE_IDLE   = 3'h1;
	localparam logic [2:0] MODE_PDCORE = 3'h2;
	localparam logic [2:0] MODE_PDCP   = 3'h3;
	localparam logic [2:0] MODE_PDALL  = 3'h4;
	localparam logic [2:0] MODE_WAKE   = 3'h5;

endpackage

// >>> verilog/lpm_tmr_if.sv
// Carrier between the mode controller and its wake-up timer
`timescale 1ns/100ps
`default_nettype none

interface lpm_tmr_if;
	import lpm_pkg::*;

	logic     load;
	lpm_cnt_t load_val;
	logic     done;

	modport ctrl (output load, output load_val, input done);
	modport tmr  (input load, input load_val, output done);
endinterface

`default_nettype wire

// >>> verilog/lpm_wake_tmr.sv
// Down counter that times the wake-up latency
`timescale 1ns/100ps
`default_nettype none

module lpm_wake_tmr (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Control side
	lpm_tmr_if.tmr    tif
);
	import lpm_pkg::*;

	typedef struct packed {
		lpm_cnt_t cnt;
	} lpm_tmr_s;

	lpm_tmr_s st_q;
	lpm_tmr_s st_d;

	always_comb begin
		st_d = st_q;
		if (tif.load) begin
			st_d.cnt = tif.load_val;
		end else if (st_q.cnt != TMR_RST) begin
			st_d.cnt = st_q.cnt - TMR_ONE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '{cnt: TMR_RST};
		end else begin
			st_q <= st_d;
		end
	end

	// Last cycle of the wait
	assign tif.done = (st_q.cnt == TMR_ONE);

endmodule

`default_nettype wire

// >>> verif/lpm_ctrl_tb_top.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/100ps
`default_nettype none

module lpm_ctrl_tb_top;
	import lpm_pkg::*;

	logic       clk_sys    = 1'h0;
	logic       rst_n      = 1'h0;
	logic       idle_exec  = 1'h0;
	logic       full_bit   = 1'h0;
	logic       all_bit    = 1'h0;
	logic       core_bit   = 1'h0;
	logic       irq_req    = 1'h0;
	logic       wake_evt   = 1'h0;
	logic       core_stall;
	logic       resume;
	logic       pipe_flush;
	logic       core_en;
	logic       periph_en;
	logic       pll_en;
	logic [2:0] mode;
	int         fail_count = 0;
	int         num_checks = 0;

	always #5 clk_sys = ~clk_sys;

	lpm_ctrl i_dut (
		.CLK_SYS                  (clk_sys),
		.RST_N                    (rst_n),
		.IDLE_EXEC                (idle_exec),
		.CORE_STALL               (core_stall),
		.RESUME                   (resume),
		.PIPE_FLUSH               (pipe_flush),
		.FULL_POWER_DOWN_BIT      (full_bit),
		.STOP_CORE_AND_PERIPH_BIT (all_bit),
		.STOP_CORE_CLOCK_BIT      (core_bit),
		.IRQ_REQ                  (irq_req),
		.WAKE_EVT                 (wake_evt),
		.CORE_CLK_EN              (core_en),
		.PERIPH_CLK_EN            (periph_en),
		.PLL_EN                   (pll_en),
		.MODE                     (mode)
	);

	////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Flags packed as resume, flush, stall, core, periph, pll, then mode
	function automatic logic [8:0] st();
		return {resume, pipe_flush, core_stall, core_en, periph_en, pll_en,
			mode};
	endfunction

	task automatic enter(input logic f, input logic a, input logic c);
		@(posedge clk_sys);
		full_bit  <= f;
		all_bit   <= a;
		core_bit  <= c;
		// Idle is only issued while no interrupt is pending
		idle_exec <= 1'h1;
		@(posedge clk_sys);
		idle_exec <= 1'h0;
		#1;
	endtask

	// Counts edges after the sampling edge until the resume pulse shows
	task automatic wake(input logic evt, output int k, output logic [8:0] mid);
		@(posedge clk_sys);
		irq_req  <= ~evt;
		wake_evt <= evt;
		@(posedge clk_sys);
		#1;
		mid = st();
		k = 0;
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (resume !== 1'h1 && k < 600);
	endtask

	// Drops wake sources one edge after the pulse; a stuck pulse shows here
	task automatic rel(output logic [8:0] after);
		@(posedge clk_sys);
		irq_req  <= 1'h0;
		wake_evt <= 1'h0;
		full_bit <= 1'h0;
		all_bit  <= 1'h0;
		core_bit <= 1'h0;
		#1;
		after = st();
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_no_idle();
		@(posedge clk_sys);
		full_bit <= 1'h1;
		all_bit  <= 1'h1;
		irq_req  <= 1'h1;
		repeat (4) @(posedge clk_sys);
		#1;
		chk(st(), {6'h07, MODE_RUN});
		@(posedge clk_sys);
		full_bit <= 1'h0;
		all_bit  <= 1'h0;
		irq_req  <= 1'h0;
	endtask

	task automatic t_idle();
		int k;
		logic [8:0] m;
		enter(1'h0, 1'h0, 1'h0);
		chk(st(), {6'h0F, MODE_IDLE});
		repeat (3) @(posedge clk_sys);
		#1;
		chk(st(), {6'h0F, MODE_IDLE});
		// A second idle with power-down bits must not change the state
		enter(1'h1, 1'h1, 1'h0);
		chk(st(), {6'h0F, MODE_IDLE});
		wake(1'h0, k, m);
		chk(9'(k), 9'(LAT_IDLE_CYC - 1));
		chk(st(), {6'h27, MODE_RUN});
		rel(m);
		chk(m, {6'h07, MODE_RUN});
	endtask

	task automatic t_pdcore();
		int k;
		logic [8:0] m;
		enter(1'h0, 1'h0, 1'h1);
		chk(st(), {6'h0B, MODE_PDCORE});
		wake(1'h0, k, m);
		chk(9'(k), 9'(LAT_PDCORE_CYC - 1));
		chk(st(), {6'h27, MODE_RUN});
		rel(m);
	endtask

	task automatic t_pdcp();
		int k;
		logic [8:0] m;
		enter(1'h0, 1'h1, 1'h0);
		chk(st(), {6'h09, MODE_PDCP});
		// Synchroniser on the wake pin adds two edges
		wake(1'h1, k, m);
		chk(9'(k), 9'(LAT_PDCP_CYC + 1));
		chk(st(), {6'h37, MODE_RUN});
		rel(m);
	endtask

	task automatic t_pdall();
		int k;
		logic [8:0] m;
		enter(1'h1, 1'h0, 1'h0);
		chk(st(), {6'h08, MODE_PDALL});
		wake(1'h0, k, m);
		chk(m, {6'h0F, MODE_WAKE});
		chk(9'(k), 9'(LAT_PDALL_CYC - 1));
		chk(st(), {6'h37, MODE_RUN});
		rel(m);
	endtask

	task automatic t_prio();
		int k;
		logic [8:0] m;
		enter(1'h1, 1'h1, 1'h1);
		chk(st(), {6'h08, MODE_PDALL});
		wake(1'h0, k, m);
		rel(m);
		enter(1'h0, 1'h1, 1'h1);
		chk(st(), {6'h09, MODE_PDCP});
		wake(1'h0, k, m);
		chk(9'(k), 9'(LAT_PDCP_CYC - 1));
		rel(m);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Sequence and verdict
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'h1;
		// Internal reset copy needs two edges before a request is taken
		repeat (3) @(posedge clk_sys);
		t_no_idle();
		t_idle();
		t_pdcore();
		t_pdcp();
		t_pdall();
		t_prio();
		end_sim();
	end

	// Whole run is well under 2000 cycles
	initial begin
		#50000;
		fail_count++;
		end_sim();
	end
endmodule

`default_nettype wire
